// ### design/rli_map.svh
`ifndef RLI_MAP_SVH
`define RLI_MAP_SVH
`define RLI_ADDR_CTRL_OFS 8'hAC
`define RLI_DATA_OFS 8'hAD
`define RLI_KEY_OFS 8'hAE
`define RLI_KEY_FIRST 8'hA5
`define RLI_KEY_SECOND 8'hF1
`define RLI_ADDR_CTRL_RST 8'h00
`define RLI_DATA_RST 8'h00
`define RLI_BUSY_BIT 7
`define RLI_AUTO_READ_ENABLE_BIT 6
`define RLI_SHORT_BIT 4
`define RLI_STROBE_NORMAL 3'h7
`define RLI_STROBE_SHORT 3'h6
`define RLI_CAP_FIRST 4'h0
`define RLI_CAP_LAST 4'h3
`define RLI_ALM_FIRST 4'h8
`define RLI_ALM_LAST 4'hB
`endif

// ### design/rli_pkg.sv
package rli_pkg;
    typedef enum logic [3:0] {
        RLI_LOCKED = 4'h1,
        RLI_FIRST = 4'h2,
        RLI_OPEN = 4'h4,
        RLI_DEAD = 4'h8
    } rli_lock_t;
    typedef enum logic [2:0] {
        RLI_IDLE = 3'h1,
        RLI_RD = 3'h2,
        RLI_WR = 3'h4
    } rli_acc_t;
endpackage : rli_pkg

// ### design/rli_access.sv
// Behaviour
// - Key read returns lock state code
// - Codes A5 then F1 unlock the port
// - Wrong second code disables until reset
// - Any key write while unlocked relocks
// - Disabled state ignores all key writes
// - Bit 7 busy; writing 1 starts read
// - Bit 6 enables autoread
// - Bit 5 reads zero, writes ignored
// - Bit 4 selects short strobe
// - Low nibble selects internal register
// - Capture/alarm accesses advance address
// - Bad code or locked access disables
// - Data write starts indirect write
// - Autoread: data read starts next read
// - Increment only in 0-3 and 8-B
`include "rli_map.svh"
module rli_access
    import rli_pkg::*;
(
    input wire logic clock,
    input wire logic nrst,
    input wire logic [7:0] sfrAddr,
    input wire logic [7:0] sfrWdata,
    input wire logic sfrWr,
    input wire logic sfrRd,
    output logic [7:0] sfrRdata,
    output logic [3:0] coreAddr,
    output logic [7:0] coreWdata,
    output logic coreWr,
    output logic coreRd,
    input wire logic [7:0] coreRdata
);
    rli_lock_t lock_reg, lock_next;
    rli_acc_t acc_reg, acc_next;
    logic [7:0] ctrl_reg, ctrl_next;
    logic [7:0] data_reg, data_next;
    logic [2:0] cnt_reg, cnt_next;
    logic [7:0] lockCode;
    logic keyWr, ctrlWr, dataWr, dataRd, busy, incAddr, dead;

    assign keyWr = sfrWr && sfrAddr == `RLI_KEY_OFS;
    assign ctrlWr = sfrWr && sfrAddr == `RLI_ADDR_CTRL_OFS;
    assign dataWr = sfrWr && sfrAddr == `RLI_DATA_OFS;
    assign dataRd = sfrRd && sfrAddr == `RLI_DATA_OFS;
    assign busy = acc_reg != RLI_IDLE;
    assign dead = lock_reg == RLI_DEAD;

    always_comb begin
        case (lock_reg)
            RLI_LOCKED: lockCode = 8'h00;
            RLI_FIRST: lockCode = 8'h01;
            RLI_OPEN: lockCode = 8'h02;
            default: lockCode = 8'h03;
        endcase
    end

    // Lock machine
    always_comb begin
        lock_next = lock_reg;
        case (lock_reg)
            RLI_LOCKED: begin
                if (keyWr) begin
                    lock_next = (sfrWdata == `RLI_KEY_FIRST) ? RLI_FIRST : RLI_DEAD;
                end else if (ctrlWr || dataWr || dataRd) begin
                    lock_next = RLI_DEAD;
                end
            end
            RLI_FIRST: begin
                if (keyWr) begin
                    lock_next = (sfrWdata == `RLI_KEY_SECOND) ? RLI_OPEN : RLI_DEAD;
                end else if (ctrlWr || dataWr || dataRd) begin
                    lock_next = RLI_DEAD;
                end
            end
            RLI_OPEN: begin
                if (keyWr) begin
                    lock_next = RLI_LOCKED;
                end
            end
            RLI_DEAD: lock_next = RLI_DEAD;
            default: lock_next = RLI_DEAD;
        endcase
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            lock_reg <= RLI_LOCKED;
        end else begin
            lock_reg <= lock_next;
        end
    end

    // Address advances only inside the two multi-byte groups
    assign incAddr = (ctrl_reg[3:0] <= `RLI_CAP_LAST) ||
        (ctrl_reg[3:0] >= `RLI_ALM_FIRST && ctrl_reg[3:0] <= `RLI_ALM_LAST);

    // Access engine; the unlocked state gates starting an access, a running one completes even after relock
    always_comb begin
        acc_next = acc_reg;
        ctrl_next = ctrl_reg;
        data_next = data_reg;
        cnt_next = cnt_reg;
        if (acc_reg != RLI_IDLE) begin
            if (cnt_reg == 3'h1) begin
                acc_next = RLI_IDLE;
                if (acc_reg == RLI_RD) begin
                    data_next = coreRdata;
                end
                if (incAddr) begin
                    ctrl_next[3:0] = ctrl_reg[3:0] + 4'h1;
                end
            end
            cnt_next = cnt_reg - 3'h1;
        end else if (lock_reg == RLI_OPEN) begin
            if (ctrlWr) begin
                ctrl_next = {1'b0, sfrWdata[6], 1'b0, sfrWdata[4], sfrWdata[3:0]};
            end
            if (ctrlWr && sfrWdata[`RLI_BUSY_BIT]) begin
                acc_next = RLI_RD;
            end else if (dataWr) begin
                acc_next = RLI_WR;
                data_next = sfrWdata;
            end else if (dataRd && ctrl_reg[`RLI_AUTO_READ_ENABLE_BIT]) begin
                acc_next = RLI_RD;
            end
            if (acc_next != RLI_IDLE) begin
                cnt_next = (ctrlWr ? sfrWdata[`RLI_SHORT_BIT] : ctrl_reg[`RLI_SHORT_BIT]) ?
                    `RLI_STROBE_SHORT : `RLI_STROBE_NORMAL;
            end
        end
    end

    always_ff @(posedge clock) begin
        if (!nrst) begin
            acc_reg <= RLI_IDLE;
            ctrl_reg <= `RLI_ADDR_CTRL_RST;
            data_reg <= `RLI_DATA_RST;
            cnt_reg <= 3'h0;
        end else begin
            acc_reg <= acc_next;
            ctrl_reg <= ctrl_next;
            data_reg <= data_next;
            cnt_reg <= cnt_next;
        end
    end

    assign coreAddr = ctrl_reg[3:0];
    assign coreWdata = data_reg;
    assign coreRd = acc_reg == RLI_RD;
    assign coreWr = acc_reg == RLI_WR;

    // Disabled port hides address and data contents
    always_comb begin
        sfrRdata = 8'h00;
        if (sfrAddr == `RLI_KEY_OFS) begin
            sfrRdata = lockCode;
        end else if (sfrAddr == `RLI_ADDR_CTRL_OFS && !dead) begin
            sfrRdata = {busy, ctrl_reg[6], 1'b0, ctrl_reg[4:0]};
        end else if (sfrAddr == `RLI_DATA_OFS && !dead) begin
            sfrRdata = data_reg;
        end
    end

    a_state_code: assert property (@(posedge clock) disable iff (!nrst)
        sfrAddr == `RLI_KEY_OFS |-> sfrRdata[7:2] == 6'h00)
        else $error("key status code out of range");
    a_unlock_seq: assert property (@(posedge clock) disable iff (!nrst)
        lock_reg == RLI_FIRST && keyWr && sfrWdata == `RLI_KEY_SECOND
        |=> lockCode == 8'h02)
        else $error("second code did not unlock");
    a_bad_second: assert property (@(posedge clock) disable iff (!nrst)
        lock_reg == RLI_FIRST && keyWr && sfrWdata != `RLI_KEY_SECOND
        |=> lockCode == 8'h03)
        else $error("bad second code did not disable");
    a_relock: assert property (@(posedge clock) disable iff (!nrst)
        lock_reg == RLI_OPEN && keyWr |=> lockCode == 8'h00)
        else $error("key write did not relock");
    a_dead_sticky: assert property (@(posedge clock) disable iff (!nrst)
        dead |=> dead)
        else $error("disabled state left without reset");
    a_busy_start: assert property (@(posedge clock) disable iff (!nrst)
        lock_reg == RLI_OPEN && !busy && ctrlWr && sfrWdata[`RLI_BUSY_BIT]
        |=> coreRd && busy)
        else $error("busy write did not start read");
    a_strobe_len: assert property (@(posedge clock) disable iff (!nrst)
        !busy ##1 busy && cnt_reg == `RLI_STROBE_SHORT |-> busy [*6] ##1 !busy)
        else $error("short strobe length wrong");
    a_strobe_norm: assert property (@(posedge clock) disable iff (!nrst)
        !busy ##1 busy && cnt_reg == `RLI_STROBE_NORMAL |-> busy [*7] ##1 !busy)
        else $error("normal strobe length wrong");
    a_bit5_zero: assert property (@(posedge clock) disable iff (!nrst)
        sfrAddr == `RLI_ADDR_CTRL_OFS |-> !sfrRdata[5])
        else $error("unused bit reads one");
    a_addr_inc: assert property (@(posedge clock) disable iff (!nrst)
        busy && cnt_reg == 3'h1 && ctrl_reg[3:0] == 4'h2
        |=> ctrl_reg[3:0] == 4'h3)
        else $error("address did not advance");
    a_no_inc: assert property (@(posedge clock) disable iff (!nrst)
        busy && cnt_reg == 3'h1 && ctrl_reg[3:0] == 4'h4
        |=> ctrl_reg[3:0] == 4'h4)
        else $error("address advanced outside groups");
    a_locked_touch: assert property (@(posedge clock) disable iff (!nrst)
        lock_reg == RLI_LOCKED && (ctrlWr || dataWr || dataRd) |=> dead)
        else $error("locked access did not disable");
    a_data_wr: assert property (@(posedge clock) disable iff (!nrst)
        lock_reg == RLI_OPEN && !busy && dataWr |=> coreWr && coreWdata == $past(sfrWdata))
        else $error("data write did not start");
    a_auto_read: assert property (@(posedge clock) disable iff (!nrst)
        lock_reg == RLI_OPEN && !busy && dataRd && ctrl_reg[`RLI_AUTO_READ_ENABLE_BIT] |=> coreRd)
        else $error("data read did not start autoread");
    a_dead_hide: assert property (@(posedge clock) disable iff (!nrst)
        dead && sfrAddr != `RLI_KEY_OFS |-> sfrRdata == 8'h00)
        else $error("disabled port shows register contents");

    c_unlock: cover property (@(posedge clock) lock_reg == RLI_FIRST ##1 lock_reg == RLI_OPEN);
    c_read: cover property (@(posedge clock) coreRd ##1 !coreRd);
    c_write: cover property (@(posedge clock) coreWr ##1 !coreWr);
    c_dead: cover property (@(posedge clock) !dead ##1 dead);
    c_auto: cover property (@(posedge clock) dataRd && ctrl_reg[`RLI_AUTO_READ_ENABLE_BIT] && !busy ##1 coreRd);
endmodule : rli_access

// ### tb/rli_core_model.sv
module rli_core_model (
    input wire logic clock,
    input wire logic [3:0] coreAddr,
    input wire logic [7:0] coreWdata,
    input wire logic coreWr,
    input wire logic coreRd,
    output logic [7:0] coreRdata
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] mem [16];
    logic [7:0] junk = 8'h5A;
    always @(posedge clock) begin
        junk <= ~junk;
        if (coreWr) mem[coreAddr] <= coreWdata;
    end
    // Outside a strobe the bus shows garbage, not the last byte
    assign coreRdata = coreRd ? mem[coreAddr] : junk;
endmodule : rli_core_model

// ### tb/rtc_locked_indirect_access_bench.sv
`include "rli_map.svh"
module rtc_locked_indirect_access_bench;
    timeunit 1ns;
    timeprecision 1ns;
    logic clock = 0, nrst = 0, sfrWr = 0, sfrRd = 0, coreWr, coreRd, smp = 0;
    logic [7:0] sfrAddr = 8'h00, sfrWdata = 8'h00, sfrRdata, coreWdata, coreRdata;
    logic [7:0] r = 8'h30;
    logic [7:0] mem [4];
    logic [3:0] coreAddr;
    logic [7:0] q [$];
    int errors = 0, checked = 0, len;
    always #10 clock = ~clock;
    rli_access dut_u (.clock(clock), .nrst(nrst), .sfrAddr(sfrAddr), .sfrWdata(sfrWdata),
        .sfrWr(sfrWr), .sfrRd(sfrRd), .sfrRdata(sfrRdata), .coreAddr(coreAddr),
        .coreWdata(coreWdata), .coreWr(coreWr), .coreRd(coreRd), .coreRdata(coreRdata));
    rli_core_model core_u (.clock(clock), .coreAddr(coreAddr), .coreWdata(coreWdata),
        .coreWr(coreWr), .coreRd(coreRd), .coreRdata(coreRdata));
    function automatic logic [7:0] lfsr(input logic [7:0] s);
        return {s[6:0], s[7] ^ s[5] ^ s[4] ^ s[3]};
    endfunction : lfsr
    task check(input logic [7:0] seen, input logic [7:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("ERROR %0t seen %h expected %h", $time, seen, exp);
        end
    endtask : check
    task conclude;
        $display("errors %0d checked %0d", errors, checked);
        if (errors == 0 && checked > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask : conclude
    task rst;
        nrst = 0;
        repeat (2) @(negedge clock);
        nrst = 1;
    endtask : rst
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clock);
        sfrAddr = a;
        sfrWdata = d;
        sfrWr = 1;
        @(negedge clock);
        sfrWr = 0;
    endtask : wr
    task rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clock);
        sfrAddr = a;
        sfrRd = 1;
        smp = 1;
        q.push_back(e);
        @(negedge clock);
        sfrRd = 0;
        smp = 0;
    endtask : rd
    // Counts strobe cycles while polling busy
    task idle;
        int n;
        n = 0;
        len = 0;
        sfrAddr = `RLI_ADDR_CTRL_OFS;
        #1;
        while (sfrRdata[7] !== 1'b0 && n < 20) begin
            len += int'(coreRd | coreWr);
            @(negedge clock);
            n++;
        end
        check({7'h00, sfrRdata[7]}, 8'h00);
    endtask : idle
    always @(posedge clock) if (smp) check(sfrRdata, q.pop_front());
    initial begin
        repeat (3000) @(posedge clock);
        errors++;
        conclude();
    end
    initial begin
        rst();
        rd(`RLI_KEY_OFS, 8'h00);
        wr(`RLI_KEY_OFS, `RLI_KEY_FIRST);
        rd(`RLI_KEY_OFS, 8'h01);
        wr(`RLI_KEY_OFS, `RLI_KEY_SECOND);
        rd(`RLI_KEY_OFS, 8'h02);
        wr(`RLI_ADDR_CTRL_OFS, 8'h30);
        rd(`RLI_ADDR_CTRL_OFS, 8'h10);
        for (int i = 0; i < 4; i++) begin
            r = lfsr(r);
            mem[i] = r;
            wr(`RLI_DATA_OFS, r);
            idle();
            check(len[7:0], 8'h06);
        end
        rd(`RLI_ADDR_CTRL_OFS, 8'h14);
        wr(`RLI_ADDR_CTRL_OFS, 8'h83);
        idle();
        check(len[7:0], 8'h07);
        rd(`RLI_DATA_OFS, mem[3]);
        rd(`RLI_ADDR_CTRL_OFS, 8'h04);
        wr(`RLI_DATA_OFS, 8'hAA);
        idle();
        rd(`RLI_ADDR_CTRL_OFS, 8'h04);
        wr(`RLI_ADDR_CTRL_OFS, 8'hC0);
        for (int i = 0; i < 4; i++) begin
            idle();
            rd(`RLI_DATA_OFS, mem[i]);
        end
        idle();
        rd(`RLI_ADDR_CTRL_OFS, 8'h44);
        wr(`RLI_KEY_OFS, 8'h33);
        rd(`RLI_KEY_OFS, 8'h00);
        wr(`RLI_ADDR_CTRL_OFS, 8'h05);
        rd(`RLI_KEY_OFS, 8'h03);
        wr(`RLI_KEY_OFS, `RLI_KEY_FIRST);
        rd(`RLI_KEY_OFS, 8'h03);
        rst();
        wr(`RLI_KEY_OFS, `RLI_KEY_FIRST);
        wr(`RLI_KEY_OFS, 8'h12);
        rd(`RLI_KEY_OFS, 8'h03);
        rd(`RLI_ADDR_CTRL_OFS, 8'h00);
        rd(`RLI_DATA_OFS, 8'h00);
        rst();
        rd(`RLI_DATA_OFS, 8'h00);
        rd(`RLI_KEY_OFS, 8'h03);
        rst();
        wr(`RLI_KEY_OFS, 8'h5A);
        rd(`RLI_KEY_OFS, 8'h03);
        repeat (2) @(negedge clock);
        conclude();
    end
endmodule : rtc_locked_indirect_access_bench
